//--- design/sac_averaging_ctrl.sv
// command decoder and averaging datapath of the sensor averaging control
// assumes rx bytes, samples and output requests come from logic on clk
module sac_averaging_ctrl (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       rx_valid,
  input  wire logic [7:0]                 rx_byte,
  input  wire logic [7:0]                 unit_addr,
  input  wire logic                       sample_valid,
  input  wire logic [sac_pkg::SAC_SAMPLE_W-1:0] sample,
  input  wire logic                       output_req,
  output sac_pkg::sac_cfg_t               cfg,
  output sac_pkg::sac_report_t            report,
  output logic                            report_valid,
  output logic                            cmd_done,
  output logic                            cmd_reject
);
  import sac_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // frame receiver
  sac_rx_state_t rx_state;
  logic [15:0]   sum;
  logic [7:0]    addr_b;
  logic [7:0]    c1;
  logic [7:0]    c2;
  logic          ext;

  wire logic [15:0] sum_plus  = sum + {8'h00, rx_byte};
  wire logic        frame_end = rx_valid && (rx_state == SAC_RX_CSUM);
  wire logic        csum_ok   = rx_byte == sac_csum(sum);
  wire logic        exec_ok   = frame_end && csum_ok && (addr_b == unit_addr);
  wire logic        csum_bad  = frame_end && !csum_ok;

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state <= SAC_RX_IDLE;
      sum      <= 16'h0000;
      addr_b   <= 8'h00;
      c1       <= 8'h00;
      c2       <= 8'h00;
      ext      <= 1'b0;
    end else if (rx_valid) begin
      sum <= sum_plus;
      unique case (rx_state)
        SAC_RX_IDLE: begin
          sum <= {8'h00, rx_byte};
          ext <= rx_byte == SAC_PFX_EXT;
          if (rx_byte == SAC_PFX_LONG || rx_byte == SAC_PFX_EXT) begin
            rx_state <= SAC_RX_ADDR;
          end
        end
        SAC_RX_ADDR: begin
          addr_b   <= rx_byte;
          rx_state <= SAC_RX_C1;
        end
        SAC_RX_C1: begin
          c1       <= rx_byte;
          rx_state <= ext ? SAC_RX_C2 : SAC_RX_CSUM;
        end
        SAC_RX_C2: begin
          c2       <= rx_byte;
          rx_state <= SAC_RX_CSUM;
        end
        SAC_RX_CSUM: rx_state <= SAC_RX_IDLE;
        default:     rx_state <= SAC_RX_IDLE;
      endcase
    end
  end

  // command decode
  wire logic do_avg_on   = exec_ok && !ext && c1 == SAC_CMD_AVG_ON;
  wire logic do_avg_off  = exec_ok && !ext && c1 == SAC_CMD_AVG_OFF;
  wire logic do_cont_on  = exec_ok && !ext && c1 == SAC_CMD_CONT_ON;
  wire logic do_cont_off = exec_ok && !ext && c1 == SAC_CMD_CONT_OFF;
  wire logic do_tc_avg   = exec_ok && ext && c1 == SAC_CMD_TC_AVG;
  wire logic do_tc_cont  = exec_ok && ext && c1 == SAC_CMD_TC_CONT;
  wire logic do_set_tc   = exec_ok && ext && (c1 == SAC_CMD_SET_TC || do_tc_avg || do_tc_cont);
  wire logic known_cmd   = do_avg_on || do_avg_off || do_cont_on || do_cont_off || do_set_tc;
  wire logic restart     = do_avg_on || do_avg_off || do_cont_on;

  sac_cfg_t next_cfg;
  always_comb begin
    next_cfg = cfg;
    if (do_avg_off) begin
      next_cfg.avg_en  = 1'b0;
      next_cfg.cont_en = 1'b0;
    end
    if (do_avg_on || do_tc_avg) begin
      next_cfg.avg_en = 1'b1;
    end
    if (do_cont_on || do_tc_cont) begin
      next_cfg.avg_en  = 1'b1;
      next_cfg.cont_en = 1'b1;
    end
    if (do_cont_off) begin
      next_cfg.cont_en = 1'b0;
    end
    if (do_set_tc) begin
      next_cfg.tc = c2;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg        <= '{avg_en: SAC_AVG_RESET, cont_en: SAC_CONT_RESET, tc: SAC_TC_RESET};
      cmd_done   <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cfg        <= next_cfg;
      cmd_done   <= known_cmd;
      cmd_reject <= csum_bad;
    end
  end

  // averaging datapath
  sac_av_state_t           av_state;
  logic signed [SAC_ACC_W-1:0]    acc;
  logic [7:0]              n;
  logic [SAC_SAMPLE_W-1:0] hold;
  logic [SAC_SAMPLE_W-1:0] xs;
  logic [SAC_SAMPLE_W-1:0] last;
  logic                    pend_s;
  logic                    pend_o;
  logic                    discard;
  logic                    div_start;
  logic [7:0]              div_divisor;
  logic                    div_done;
  logic signed [SAC_ACC_W-1:0]    div_q;

  wire logic [7:0]          lim      = (cfg.tc == 8'h00) ? 8'h01 : cfg.tc;
  wire logic                av_idle  = av_state == SAC_AV_IDLE;
  wire logic                serve_s  = av_idle && pend_s && !restart;
  wire logic                serve_o  = av_idle && pend_o && !pend_s && !restart;
  wire logic                samp_exp = cfg.avg_en && n >= lim;
  wire logic                out_div  = cfg.avg_en && n != 8'h00;
  wire logic signed [SAC_ACC_W-1:0] hold_x   = {{(SAC_ACC_W-SAC_SAMPLE_W){hold[SAC_SAMPLE_W-1]}}, hold};
  wire logic signed [SAC_ACC_W-1:0] xs_x     = {{(SAC_ACC_W-SAC_SAMPLE_W){xs[SAC_SAMPLE_W-1]}}, xs};
  wire logic                samp_fin = av_state == SAC_AV_SAMP && div_done && !discard && !restart;
  wire logic                out_fin  = av_state == SAC_AV_OUT && div_done && !discard && !restart;

  sac_divider u_div (
    .clk      (clk),
    .reset    (reset),
    .start    (div_start),
    .dividend (acc),
    .divisor  (div_divisor),
    .done     (div_done),
    .quotient (div_q)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      av_state    <= SAC_AV_IDLE;
      div_start   <= 1'b0;
      div_divisor <= 8'h01;
      discard     <= 1'b0;
      xs          <= '0;
    end else begin
      div_start <= 1'b0;
      unique case (av_state)
        SAC_AV_IDLE: begin
          if (serve_s && samp_exp) begin
            div_start   <= 1'b1;
            div_divisor <= lim;
            xs          <= hold;
            av_state    <= SAC_AV_SAMP;
          end else if (serve_o && out_div) begin
            div_start   <= 1'b1;
            div_divisor <= n;
            av_state    <= SAC_AV_OUT;
          end
        end
        SAC_AV_SAMP, SAC_AV_OUT: begin
          if (div_done) begin
            av_state <= SAC_AV_IDLE;
            discard  <= 1'b0;
          end
        end
        default: av_state <= SAC_AV_IDLE;
      endcase
      if (restart && !av_idle && !div_done) begin
        discard <= 1'b1;
      end
    end
  end

  // sum and count; restart overrides any update in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= '0;
      n   <= 8'h00;
    end else if (restart) begin
      acc <= '0;
      n   <= 8'h00;
    end else if (serve_s && cfg.avg_en && !samp_exp) begin
      acc <= acc + hold_x;
      n   <= n + 8'h01;
    end else if (samp_fin) begin
      acc <= acc - div_q + xs_x;
      n   <= lim;
    end else if (out_fin && !cfg.cont_en) begin
      acc <= '0;
      n   <= 8'h00;
    end
  end

  // pending flags: a new event wins over the clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_s <= 1'b0;
      pend_o <= 1'b0;
      hold   <= '0;
      last   <= '0;
    end else begin
      if ((serve_s && !samp_exp) || samp_fin) begin
        pend_s <= 1'b0;
      end
      if ((serve_o && !out_div) || out_fin) begin
        pend_o <= 1'b0;
      end
      if (serve_s) begin
        last <= hold;
      end
      if (sample_valid) begin
        pend_s <= 1'b1;
        hold   <= sample;
      end
      if (output_req) begin
        pend_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      report       <= '0;
      report_valid <= 1'b0;
    end else begin
      report_valid <= (serve_o && !out_div) || out_fin;
      if (serve_o && !out_div) begin
        report <= '{value: last, count: cfg.avg_en ? 8'h00 : 8'h01};
      end else if (out_fin) begin
        report <= '{value: div_q[SAC_SAMPLE_W-1:0], count: n};
      end
    end
  end

  property p_off_clears;
    do_avg_off |=> !cfg.avg_en && !cfg.cont_en;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("averaging off left a flag set");

  property p_on_std_only;
    do_avg_on |=> cfg.avg_en && (cfg.cont_en == $past(cfg.cont_en));
  endproperty
  a_on_std_only: assert property (p_on_std_only) else $error("averaging on changed continuous flag");

  property p_cont_on;
    (do_cont_on || do_tc_cont) |=> cfg.avg_en && cfg.cont_en;
  endproperty
  a_cont_on: assert property (p_cont_on) else $error("continuous on did not set both flags");

  property p_cont_off;
    do_cont_off |=> !cfg.cont_en && (cfg.avg_en == $past(cfg.avg_en));
  endproperty
  a_cont_off: assert property (p_cont_off) else $error("continuous off touched standard flag");

  property p_set_tc;
    do_set_tc |=> cfg.tc == $past(c2);
  endproperty
  a_set_tc: assert property (p_set_tc) else $error("time constant not loaded");

  property p_bad_frame;
    csum_bad |=> $stable(cfg) && !cmd_done && cmd_reject;
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad checksum frame had an effect");

  property p_csum_match;
    exec_ok |-> rx_byte == ~(8'(sum[7:0] + sum[15:8]));
  endproperty
  a_csum_match: assert property (p_csum_match) else $error("command executed with wrong checksum");

  property p_restart;
    (do_avg_on || do_cont_on) |=> n == 8'h00 && acc == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("enable did not restart the average");

  property p_joint_keeps;
    (do_tc_avg && av_idle && !pend_s && !pend_o) |=> n == $past(n) && acc == $past(acc);
  endproperty
  a_joint_keeps: assert property (p_joint_keeps) else $error("joint command restarted average");

  property p_passthru;
    (serve_o && !cfg.avg_en) |=> report_valid && report.count == 8'h01 && report.value == $past(last);
  endproperty
  a_passthru: assert property (p_passthru) else $error("bypass report wrong");

  property p_report_count;
    out_fin |=> report_valid && report.count == $past(n);
  endproperty
  a_report_count: assert property (p_report_count) else $error("report count differs from sample count");

  property p_std_reset;
    (out_fin && !cfg.cont_en && !restart) |=> n == 8'h00;
  endproperty
  a_std_reset: assert property (p_std_reset) else $error("standard average not restarted");

  property p_cont_keeps;
    (out_fin && cfg.cont_en && !restart) |=> n == $past(n);
  endproperty
  a_cont_keeps: assert property (p_cont_keeps) else $error("continuous average was restarted");

  property p_exp_start;
    (serve_s && samp_exp) |=> av_state == SAC_AV_SAMP && div_start;
  endproperty
  a_exp_start: assert property (p_exp_start) else $error("exponential step not started");

  c_cont_report: cover property (out_fin && cfg.cont_en);
  c_exp_step:    cover property (samp_fin);
  c_bad_frame:   cover property (csum_bad);
  c_joint:       cover property (do_tc_cont);

endmodule // sac_averaging_ctrl

//--- design/sac_divider.sv
// sequential signed-by-unsigned divider, one quotient bit per clock
// assumes divisor is nonzero and held stable while the division runs
module sac_divider (
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic                           start,
  input  wire logic signed [sac_pkg::SAC_ACC_W-1:0] dividend,
  input  wire logic [7:0]                     divisor,
  output logic                                done,
  output logic signed [sac_pkg::SAC_ACC_W-1:0]      quotient
);
  import sac_pkg::*;

  logic                 active;
  logic [5:0]           cnt;
  logic [8:0]           rem;
  logic [SAC_ACC_W-1:0] quo;
  logic                 neg;

  wire logic [8:0]           trial    = {rem[7:0], quo[SAC_ACC_W-1]};
  wire logic                 fits     = trial >= {1'b0, divisor};
  wire logic [8:0]           next_rem = fits ? trial - {1'b0, divisor} : trial;
  wire logic [SAC_ACC_W-1:0] next_quo = {quo[SAC_ACC_W-2:0], fits};

  always_ff @(posedge clk) begin
    if (reset) begin
      active   <= 1'b0;
      cnt      <= 6'h00;
      rem      <= 9'h000;
      quo      <= '0;
      neg      <= 1'b0;
      done     <= 1'b0;
      quotient <= '0;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        active <= 1'b1;
        cnt    <= 6'(SAC_ACC_W - 1);
        rem    <= 9'h000;
        quo    <= dividend[SAC_ACC_W-1] ? -dividend : dividend;
        neg    <= dividend[SAC_ACC_W-1];
      end else if (active) begin
        rem <= next_rem;
        quo <= next_quo;
        cnt <= cnt - 6'h01;
        if (cnt == 6'h00) begin
          active   <= 1'b0;
          done     <= 1'b1;
          quotient <= neg ? -next_quo : next_quo;
        end
      end
    end
  end

endmodule // sac_divider

//--- dv/sac_host_model.sv
// host-side model that frames averaging commands and sends them byte by byte
// assumes the caller runs on a free-running clk; bytes go out back to back
module sac_host_model (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;

  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'hFF;
  end

  // ext picks the five-byte frame; bad sends a corrupted checksum
  task automatic send(input logic [7:0] addr, input logic [7:0] c1, input logic [7:0] c2,
                      input bit ext, input bit bad);
    logic [7:0]  f [5];
    logic [15:0] sum;
    logic [7:0]  t;
    int          n;
    n = ext ? 5 : 4;
    f[0] = ext ? 8'hAF : 8'hAC;
    f[1] = addr;
    f[2] = c1;
    f[3] = c2;
    sum = 16'h0000;
    for (int i = 0; i < n - 1; i++) begin
      sum = sum + {8'h00, f[i]};
    end
    t = sum[7:0] + sum[15:8];
    f[n-1] = bad ? t : ~t;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte  = f[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    // a released line must not keep showing the last byte
    rx_byte  = ~f[n-1];
  endtask
endmodule // sac_host_model

//--- dv/tb_sensor_averaging_control.sv
// self-checking bench for the averaging command decoder and datapath
// assumes the host model drives the command bytes; samples and requests come from here
module tb_sensor_averaging_control;
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;

  localparam logic [7:0] UNIT = 8'h73;

  typedef struct packed {
    logic       ext;
    logic [7:0] code;
    logic [7:0] val;
    logic [9:0] exp_cfg;
  } sac_row_t;

  logic        clk;
  logic        reset;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic [7:0]  unit_addr;
  logic        sample_valid;
  logic [15:0] sample;
  logic        output_req;
  sac_cfg_t    cfg;
  sac_report_t report;
  logic        report_valid;
  logic        cmd_done;
  logic        cmd_reject;
  int          checks;
  int          mismatches;
  sac_row_t    rows [12];

  sac_averaging_ctrl dut (.clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .unit_addr(unit_addr), .sample_valid(sample_valid), .sample(sample), .output_req(output_req),
    .cfg(cfg), .report(report), .report_valid(report_valid), .cmd_done(cmd_done),
    .cmd_reject(cmd_reject));

  sac_host_model u_host (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // good frame to this unit, then cmd_done is looked at in the pulse cycle; the caller checks cfg
  task automatic do_cmd(input logic [7:0] c1, input logic [7:0] c2, input bit ext);
    u_host.send(UNIT, c1, c2, ext, 1'b0);
    check({31'h0, cmd_done}, 32'h1, "command done pulse");
  endtask

  task automatic put_sample(input logic [15:0] s);
    @(negedge clk);
    sample_valid = 1'b1;
    sample       = s;
    @(negedge clk);
    sample_valid = 1'b0;
    repeat (40) @(negedge clk);
  endtask

  task automatic expect_report(input logic [15:0] val, input logic [7:0] cnt);
    int n;
    n = 0;
    @(negedge clk);
    output_req = 1'b1;
    @(negedge clk);
    output_req = 1'b0;
    while (report_valid !== 1'b1 && n < 80) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, report_valid}, 32'h1, "report pulse");
    check({8'h00, report}, {8'h00, val, cnt}, "report value and count");
  endtask

  task automatic test_end(input string name);
    $display("test %s finished, mismatches so far %0d", name, mismatches);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    rows = '{
      '{1'b0, 8'hC5, 8'h00, {1'b1, 1'b0, 8'h10}},
      '{1'b0, 8'hC6, 8'h00, {1'b1, 1'b1, 8'h10}},
      '{1'b0, 8'hC7, 8'h00, {1'b1, 1'b0, 8'h10}},
      '{1'b0, 8'hC6, 8'h00, {1'b1, 1'b1, 8'h10}},
      '{1'b0, 8'hC4, 8'h00, {1'b0, 1'b0, 8'h10}},
      '{1'b0, 8'hC5, 8'h00, {1'b1, 1'b0, 8'h10}},
      '{1'b1, 8'hE4, 8'h05, {1'b1, 1'b0, 8'h05}},
      '{1'b0, 8'hC6, 8'h00, {1'b1, 1'b1, 8'h05}},
      '{1'b0, 8'hC4, 8'h00, {1'b0, 1'b0, 8'h05}},
      '{1'b1, 8'hE6, 8'h08, {1'b1, 1'b1, 8'h08}},
      '{1'b0, 8'hC4, 8'h00, {1'b0, 1'b0, 8'h08}},
      '{1'b1, 8'hE5, 8'h03, {1'b1, 1'b0, 8'h03}}};
    checks       = 0;
    mismatches   = 0;
    reset        = 1'b1;
    unit_addr    = UNIT;
    sample_valid = 1'b0;
    sample       = 16'h0000;
    output_req   = 1'b0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check({22'h0, cfg}, {22'h0, 1'b0, 1'b0, 8'h10}, "reset cfg");
    check({5'h00, report, report_valid, cmd_done, cmd_reject}, 32'h0, "reset outputs");
    test_end("reset");

    foreach (rows[i]) begin
      do_cmd(rows[i].code, rows[i].val, rows[i].ext);
      check({22'h0, cfg}, {22'h0, rows[i].exp_cfg}, "cfg after command");
    end
    test_end("command table");

    u_host.send(UNIT, 8'hC4, 8'h00, 1'b0, 1'b1);
    check({30'h0, cmd_reject, cmd_done}, 32'h2, "bad checksum pulses");
    check({22'h0, cfg}, {22'h0, 1'b1, 1'b0, 8'h03}, "cfg kept on bad checksum");
    u_host.send(UNIT ^ 8'h04, 8'hC4, 8'h00, 1'b0, 1'b0);
    check({30'h0, cmd_reject, cmd_done}, 32'h0, "other unit pulses");
    check({22'h0, cfg}, {22'h0, 1'b1, 1'b0, 8'h03}, "cfg kept for other unit");
    test_end("refused frames");

    do_cmd(8'hC4, 8'h00, 1'b0);
    put_sample(16'h1234);
    expect_report(16'h1234, 8'h01);
    test_end("averaging off");

    do_cmd(8'hE4, 8'h0A, 1'b1);
    do_cmd(8'hC5, 8'h00, 1'b0);
    put_sample(16'd10);
    put_sample(16'd20);
    put_sample(16'd31);
    expect_report(16'd20, 8'h03);
    expect_report(16'd31, 8'h00);
    test_end("uniform average");

    put_sample(16'd100);
    do_cmd(8'hC5, 8'h00, 1'b0);
    expect_report(16'd100, 8'h00);
    test_end("standalone restart");

    put_sample(16'd4);
    put_sample(16'd8);
    do_cmd(8'hE5, 8'h0A, 1'b1);
    check({22'h0, cfg}, {22'h0, 1'b1, 1'b0, 8'h0A}, "joint averaging cfg");
    expect_report(16'd6, 8'h02);
    test_end("joint keeps average");

    do_cmd(8'hE4, 8'h02, 1'b1);
    do_cmd(8'hC5, 8'h00, 1'b0);
    put_sample(16'd2);
    put_sample(16'd4);
    put_sample(16'd10);
    expect_report(16'd6, 8'h02);
    test_end("exponential range");

    do_cmd(8'hC6, 8'h00, 1'b0);
    check({22'h0, cfg}, {22'h0, 1'b1, 1'b1, 8'h02}, "continuous cfg");
    put_sample(16'd6);
    put_sample(16'd6);
    expect_report(16'd6, 8'h02);
    expect_report(16'd6, 8'h02);
    put_sample(16'd9);
    do_cmd(8'hE6, 8'h04, 1'b1);
    check({22'h0, cfg}, {22'h0, 1'b1, 1'b1, 8'h04}, "joint continuous cfg");
    expect_report(16'd7, 8'h02);
    test_end("continuous mode");

    end_of_test();
  end
endmodule // tb_sensor_averaging_control

//--- include/sac_pkg.sv
// shared constants, types and helpers of the averaging control block
// assumes one clock; command bytes arrive already deframed from a serial receiver
package sac_pkg;

  localparam int SAC_SAMPLE_W = 16;
  localparam int SAC_ACC_W    = 32;

  // frame prefixes and content bytes
  localparam logic [7:0] SAC_PFX_LONG     = 8'hAC;
  localparam logic [7:0] SAC_PFX_EXT      = 8'hAF;
  localparam logic [7:0] SAC_CMD_AVG_ON   = 8'hC5;
  localparam logic [7:0] SAC_CMD_AVG_OFF  = 8'hC4;
  localparam logic [7:0] SAC_CMD_CONT_ON  = 8'hC6;
  localparam logic [7:0] SAC_CMD_CONT_OFF = 8'hC7;
  localparam logic [7:0] SAC_CMD_SET_TC   = 8'hE4;
  localparam logic [7:0] SAC_CMD_TC_AVG   = 8'hE5;
  localparam logic [7:0] SAC_CMD_TC_CONT  = 8'hE6;

  // reset values
  localparam logic [7:0] SAC_TC_RESET     = 8'h10;
  localparam logic       SAC_AVG_RESET    = 1'b0;
  localparam logic       SAC_CONT_RESET   = 1'b0;

  typedef struct packed {
    logic       avg_en;
    logic       cont_en;
    logic [7:0] tc;
  } sac_cfg_t;

  typedef struct packed {
    logic [SAC_SAMPLE_W-1:0] value;
    logic [7:0]              count;
  } sac_report_t;

  typedef enum logic [2:0] {
    SAC_RX_IDLE = 3'b000,
    SAC_RX_ADDR = 3'b001,
    SAC_RX_C1   = 3'b011,
    SAC_RX_C2   = 3'b010,
    SAC_RX_CSUM = 3'b110
  } sac_rx_state_t;

  typedef enum logic [1:0] {
    SAC_AV_IDLE = 2'b00,
    SAC_AV_SAMP = 2'b01,
    SAC_AV_OUT  = 2'b11
  } sac_av_state_t;

  // end-around carry of the high byte, then one's complement
  function automatic logic [7:0] sac_csum(input logic [15:0] sum);
    logic [7:0] t;
    t = sum[7:0] + sum[15:8];
    return ~t;
  endfunction

endpackage
